// [verilog/status_pkg.sv]
// status reporting package: bit positions, widths, command codes
// assumes the command parser encodes each status command as one cmd_t code
package status_pkg;

	localparam int REG_W     = 8;
	localparam int OP_COND_W = 3;

	// status byte layout
	localparam int STB_OPER_SUM = 7;
	localparam int STB_MASTER   = 6;
	localparam int STB_STD_SUM  = 5;
	localparam int STB_MAV      = 4;
	localparam int STB_HW_SUM   = 2;
	localparam int STB_OPERR    = 1;

	// standard event bits
	localparam int SE_POWER_UP   = 7;
	localparam int SE_SYNTAX     = 5;
	localparam int SE_EXEC       = 4;
	localparam int SE_QUERY_LOSS = 2;
	localparam int SE_OPS_DONE   = 0;

	// operation event / condition bits
	localparam int OP_POWER_LIMIT = 2;
	localparam int OP_RAMP_DONE   = 1;
	localparam int OP_COMPLIANCE  = 0;

	localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
	localparam logic [OP_COND_W-1:0] COND_ZERO = 3'h0;

	typedef enum logic [3:0] {
		CMD_STD_MASK_WR,
		CMD_STD_MASK_RD,
		CMD_STD_EVENT_RD,
		CMD_SVC_MASK_WR,
		CMD_SVC_MASK_RD,
		CMD_STATUS_RD,
		CMD_SERIAL_POLL,
		CMD_CLEAR_STATUS,
		CMD_OPS_DONE_ARM,
		CMD_OPER_MASK_WR,
		CMD_OPER_MASK_RD,
		CMD_OPER_EVENT_RD,
		CMD_OPER_COND_RD
	} cmd_t;

endpackage

// [verilog/event_bus_if.sv]
// interface between the status top and one latched event register
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface event_bus_if #(parameter int W = 8);
	logic [W-1:0] set_bits;
	logic         clear;
	logic [W-1:0] value;

	modport owner (output set_bits, output clear, input value);
	modport latch (input set_bits, input clear, output value);
endinterface
`default_nettype wire

// [verilog/event_latch.sv]
// one latched event register: bits stick until cleared
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module event_latch #(
	parameter int W = 8
) (
	input  wire logic clk,
	input  wire logic rst_n,
	event_bus_if.latch bus
);
	typedef struct packed {
		logic [W-1:0] bits;
	} latch_state_t;

	latch_state_t st_r;
	latch_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// a set bit ignores repeats; a new event beats a coincident clear
		st_nxt.bits = (bus.clear ? '0 : st_r.bits) | bus.set_bits;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign bus.value = st_r.bits;
endmodule
`default_nettype wire

// [verilog/instrument_status_reporting.sv]
// status byte, service request and the standard and operation event sets
// assumes a parser hands over decoded commands and fault pulses on clk;
// the three operation conditions arrive asynchronously from the output stage
//
// Operation
// - service mask selects which summaries raise master
// - service mask written and read, read harmless
// - master is OR of summary AND mask
// - query returns binary-weighted eight-bit register value
// - only enable registers accept writes
// - condition register is live, never latched; condition query reads the latched operation event set
// - standard event query returns then clears
// - clear-status clears all event registers together
// - writing zero clears an enable register
// - status byte follows events, no direct clear
// - standard summary is masked OR of events
// - power-up sets standard event bit 7
// - command syntax fault sets bit 5
// - execution fault sets bit 4
// - lost query response sets bit 2
// - armed operations-done sets bit 0 when idle
// - operation summary is masked OR of events
// - operation mask and event queries; condition query clears
// - power limit sets operation bit 2
// - ramp done sets operation bit 1
// - compliance limit sets operation bit 0
// - event bits latch until cleared
// - status byte bit placement, bit 3 unused
// - request line rises with master summary rising
// - serial poll clears request, not master
`timescale 1ns/1ps
`default_nettype none
module instrument_status_reporting (
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic                            cmd_valid,
	input  wire status_pkg::cmd_t                cmd_code,
	input  wire logic [status_pkg::REG_W-1:0]    cmd_data,
	output logic                                 resp_valid,
	output logic [status_pkg::REG_W-1:0]         resp_data,
	input  wire logic                            command_syntax_fault,
	input  wire logic                            execution_fault,
	input  wire logic                            query_loss_fault,
	input  wire logic                            operations_pending,
	input  wire logic                            message_available,
	input  wire logic                            hw_error_summary,
	input  wire logic                            op_error_summary,
	input  wire logic                            power_limit,
	input  wire logic                            ramp_done,
	input  wire logic                            compliance_limit,
	output logic [status_pkg::REG_W-1:0]         status_byte,
	output logic                                 service_request
);
	import status_pkg::*;

	typedef struct packed {
		logic [OP_COND_W-1:0] cond_s1;
		logic [OP_COND_W-1:0] cond_s2;
		logic [REG_W-1:0]     std_mask;
		logic [REG_W-1:0]     oper_mask;
		logic [REG_W-1:0]     svc_mask;
		logic                 power_up_pending;
		logic                 ops_armed;
		logic                 master_prev;
		logic                 request_service_flag;
		logic [REG_W-1:0]     status_byte;
		logic                 resp_valid;
		logic [REG_W-1:0]     resp_data;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	event_bus_if #(.W(REG_W)) std_bus ();
	event_bus_if #(.W(REG_W)) oper_bus ();

	event_latch #(.W(REG_W)) std_events (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (std_bus)
	);

	event_latch #(.W(REG_W)) oper_events (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (oper_bus)
	);

	logic                 standard_event_summary;
	logic                 operation_summary;
	logic                 master_summary_flag;
	logic [REG_W-1:0]     stb_now;
	logic [REG_W-1:0]     std_set;
	logic [REG_W-1:0]     oper_set;
	logic                 std_clear;
	logic                 oper_clear;
	logic                 ops_done_fire;
	logic [OP_COND_W-1:0] cond_live;

	// condition register: synchronised copy of the live levels, no latch
	assign cond_live = st_r.cond_s2;

	// summaries use the registered event values, so they lag an event by one edge
	assign standard_event_summary = |(std_bus.value & st_r.std_mask);
	assign operation_summary      = |(oper_bus.value & st_r.oper_mask);

	always_comb
	begin
		stb_now               = REG_ZERO; // bit 0 and bit 3 stay zero
		stb_now[STB_OPER_SUM] = operation_summary;
		stb_now[STB_STD_SUM]  = standard_event_summary;
		stb_now[STB_MAV]      = message_available;
		stb_now[STB_HW_SUM]   = hw_error_summary;
		stb_now[STB_OPERR]    = op_error_summary;
		// the master bit never feeds itself through the mask
		master_summary_flag   = |(stb_now & st_r.svc_mask);
		stb_now[STB_MASTER]   = master_summary_flag;
	end

	assign ops_done_fire = st_r.ops_armed && !operations_pending;

	always_comb
	begin
		std_set                = REG_ZERO;
		std_set[SE_POWER_UP]   = st_r.power_up_pending;
		std_set[SE_SYNTAX]     = command_syntax_fault;
		std_set[SE_EXEC]       = execution_fault;
		std_set[SE_QUERY_LOSS] = query_loss_fault;
		std_set[SE_OPS_DONE]   = ops_done_fire;

		oper_set                 = REG_ZERO;
		oper_set[OP_POWER_LIMIT] = cond_live[OP_POWER_LIMIT];
		oper_set[OP_RAMP_DONE]   = cond_live[OP_RAMP_DONE];
		oper_set[OP_COMPLIANCE]  = cond_live[OP_COMPLIANCE];

		std_clear  = 1'b0;
		oper_clear = 1'b0;
		if (cmd_valid)
		begin
			unique case (cmd_code)
				CMD_STD_EVENT_RD:
					std_clear = 1'b1;
				CMD_OPER_COND_RD:
					oper_clear = 1'b1;
				CMD_CLEAR_STATUS:
				begin
					// the error sets live outside and take their own clear
					std_clear  = 1'b1;
					oper_clear = 1'b1;
				end
				default:
				begin
					std_clear  = 1'b0;
					oper_clear = 1'b0;
				end
			endcase
		end
	end

	assign std_bus.set_bits  = std_set;
	assign std_bus.clear     = std_clear;
	assign oper_bus.set_bits = oper_set;
	assign oper_bus.clear    = oper_clear;

	always_comb
	begin
		st_nxt = st_r;

		st_nxt.cond_s1 = {power_limit, ramp_done, compliance_limit};
		st_nxt.cond_s2 = st_r.cond_s1;

		// power-up bit goes in one edge after the reset has cleared the event set
		st_nxt.power_up_pending = 1'b0;
		if (ops_done_fire)
			st_nxt.ops_armed = 1'b0;

		st_nxt.resp_valid  = 1'b0;
		st_nxt.master_prev = master_summary_flag;

		// request rises only on a low-to-high master edge
		if (master_summary_flag && !st_r.master_prev)
			st_nxt.request_service_flag = 1'b1;

		if (cmd_valid)
		begin
			unique case (cmd_code)
				CMD_STD_MASK_WR:
					st_nxt.std_mask = cmd_data;
				CMD_OPER_MASK_WR:
					st_nxt.oper_mask = cmd_data;
				CMD_SVC_MASK_WR:
					st_nxt.svc_mask = cmd_data;
				CMD_STD_MASK_RD:
				begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = st_r.std_mask;
				end
				CMD_OPER_MASK_RD:
				begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = st_r.oper_mask;
				end
				CMD_SVC_MASK_RD:
				begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = st_r.svc_mask;
				end
				CMD_STD_EVENT_RD:
				begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = std_bus.value;
				end
				CMD_OPER_EVENT_RD, CMD_OPER_COND_RD:
				begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = oper_bus.value;
				end
				CMD_STATUS_RD:
				begin
					// master view of bit 6, leaves the request alone
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data  = stb_now;
				end
				CMD_SERIAL_POLL:
				begin
					st_nxt.resp_valid             = 1'b1;
					st_nxt.resp_data              = stb_now;
					st_nxt.resp_data[STB_MASTER]  = st_r.request_service_flag;
					// a rising master in the same cycle keeps the request
					if (!(master_summary_flag && !st_r.master_prev))
						st_nxt.request_service_flag = 1'b0;
				end
				CMD_CLEAR_STATUS:
					st_nxt.ops_armed = 1'b0;
				CMD_OPS_DONE_ARM:
					st_nxt.ops_armed = 1'b1;
				default:
					st_nxt.resp_valid = 1'b0;
			endcase
		end

		st_nxt.status_byte = stb_now;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r                  <= '0;
			st_r.power_up_pending <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign resp_valid      = st_r.resp_valid;
	assign resp_data       = st_r.resp_data;
	assign status_byte     = st_r.status_byte;
	assign service_request = st_r.request_service_flag;
endmodule
`default_nettype wire

// [bench/status_checker.sv]
// pin-level assertions for the status block
// assumes it is bound into instrument_status_reporting, one clock domain
`timescale 1ns/1ps
`default_nettype none
module status_checker (
	input  wire logic		clk,
	input  wire logic		rst_n,
	input  wire logic		cmd_valid,
	input  wire status_pkg::cmd_t	cmd_code,
	input  wire logic		resp_valid,
	input  wire logic [7:0]	resp_data,
	input  wire logic		message_available,
	input  wire logic		hw_error_summary,
	input  wire logic		op_error_summary,
	input  wire logic [7:0]	status_byte,
	input  wire logic		service_request
);
	import status_pkg::*;
	logic	is_rd;
	logic	poll;
	// only query codes answer; writes, clear, arm and unknown codes stay silent
	assign is_rd = cmd_code inside {CMD_STD_MASK_RD, CMD_STD_EVENT_RD, CMD_SVC_MASK_RD,
		CMD_STATUS_RD, CMD_SERIAL_POLL, CMD_OPER_MASK_RD, CMD_OPER_EVENT_RD,
		CMD_OPER_COND_RD};
	assign poll = cmd_valid && cmd_code == CMD_SERIAL_POLL;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_answer_slot: assert property ($past(rst_n) |-> resp_valid == $past(cmd_valid && is_rd))
		else $error("answer strobe out of place");
	chk_answer_hold: assert property ($past(rst_n) && !resp_valid |-> $stable(resp_data))
		else $error("answer data moved without strobe");
	chk_bit3_unused: assert property (status_byte[3] == 1'b0)
		else $error("status bit 3 set");
	chk_plain_bits: assert property ($past(rst_n) |-> status_byte[4:1] ==
		{$past(message_available), 1'b0, $past(hw_error_summary), $past(op_error_summary)})
		else $error("status level bits misplaced");
	chk_reset_clean: assert property ($rose(rst_n) |-> status_byte == 8'h00 && !service_request)
		else $error("outputs not clear after reset");
	chk_req_on_rise: assert property ($rose(service_request) |-> $rose(status_byte[STB_MASTER]))
		else $error("request without master rising");
	chk_req_holds: assert property (service_request && !poll |=> service_request)
		else $error("request dropped without poll");
	chk_poll_drops: assert property (poll |=> !service_request || $rose(status_byte[STB_MASTER]))
		else $error("request kept after poll");
	cover property (poll && service_request);
	cover property ($rose(service_request));
	cover property (cmd_valid && cmd_code == CMD_STD_EVENT_RD && status_byte[STB_STD_SUM]);
endmodule
bind instrument_status_reporting status_checker u_chk (.*);
`default_nettype wire

// [bench/bus_ctl_model.sv]
// bus controller model: sends one command and collects its answer
// assumes the answer arrives one cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
	input  wire logic		clk,
	output logic			cmd_valid = 1'b0,
	output status_pkg::cmd_t	cmd_code = status_pkg::CMD_STATUS_RD,
	output logic [7:0]		cmd_data = 8'h00,
	input  wire logic		resp_valid,
	input  wire logic [7:0]	resp_data
);
	import status_pkg::*;
	// call just after a rising edge; returns just after the answer edge
	task automatic xfer(input cmd_t c, input logic [7:0] d, output logic v,
		output logic [7:0] r);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_data <= ~d;	// released data lines do not keep their last value
		@(posedge clk);
		v = resp_valid;
		r = resp_data;
	endtask
endmodule
`default_nettype wire

// [bench/instrument_status_reporting_test.sv]
// self-checking bench for the status block
// assumes the controller model drives the command pins, the bench the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module instrument_status_reporting_test;
	import status_pkg::*;
	logic		clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		cmd_valid;
	cmd_t		cmd_code;
	logic [7:0]	cmd_data;
	logic		resp_valid;
	logic [7:0]	resp_data;
	logic [7:0]	status_byte;
	logic		service_request;
	logic		command_syntax_fault = 1'b0;
	logic		execution_fault = 1'b0;
	logic		query_loss_fault = 1'b0;
	logic		operations_pending = 1'b0;
	logic		message_available = 1'b0;
	logic		hw_error_summary = 1'b0;
	logic		op_error_summary = 1'b0;
	logic		power_limit = 1'b0;
	logic		ramp_done = 1'b0;
	logic		compliance_limit = 1'b0;
	int		error_cnt = 0;
	int		n_compared = 0;
	always #5 clk = ~clk;
	instrument_status_reporting uut (.*);
	bus_ctl_model ctl (.*);
	task automatic rd(input cmd_t c, input logic [7:0] e);
		logic v;
		logic [7:0] r;
		ctl.xfer(c, 8'h00, v, r);
		`CHK(v, 1'b1)
		`CHK(r, e)
	endtask
	task automatic wr(input cmd_t c, input logic [7:0] d);
		logic v;
		logic [7:0] r;
		ctl.xfer(c, d, v, r);
		`CHK(v, 1'b0)
	endtask
	// one-cycle fault pulse that may coincide with a command
	task automatic pulse(input logic [2:0] m);
		{command_syntax_fault, execution_fault, query_loss_fault} <= m;
		fork
			@(posedge clk) {command_syntax_fault, execution_fault, query_loss_fault} <= 3'h0;
		join_none
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		error_cnt++;
		end_sim;
	end
	initial
	begin
		idle(3);
		rst_n <= 1'b1;
		idle(2);
		rd(CMD_STD_EVENT_RD, 8'h80);
		rd(CMD_STD_EVENT_RD, 8'h00);
		rd(CMD_SVC_MASK_RD, 8'h00);
		wr(CMD_STD_MASK_WR, 8'hb5);
		rd(CMD_STD_MASK_RD, 8'hb5);
		wr(CMD_OPER_MASK_WR, 8'h02);
		rd(CMD_OPER_MASK_RD, 8'h02);
		wr(CMD_SVC_MASK_WR, 8'ha0);
		rd(CMD_SVC_MASK_RD, 8'ha0);
		rd(CMD_SVC_MASK_RD, 8'ha0);
		operations_pending <= 1'b1;
		wr(CMD_OPS_DONE_ARM, 8'h00);
		pulse(3'b100);
		idle(4);
		`CHK(status_byte[STB_STD_SUM], 1'b1)
		`CHK(service_request, 1'b1)
		pulse(3'b011);
		operations_pending <= 1'b0;
		idle(3);
		rd(CMD_STATUS_RD, 8'h60);
		`CHK(service_request, 1'b1)
		rd(CMD_SERIAL_POLL, 8'h60);
		`CHK(service_request, 1'b0)
		`CHK(status_byte[STB_MASTER], 1'b1)
		rd(CMD_STD_EVENT_RD, 8'h35);
		idle(3);
		`CHK(status_byte, 8'h00)
		{power_limit, ramp_done, compliance_limit} <= 3'b010;
		idle(2);
		{power_limit, ramp_done, compliance_limit} <= 3'b000;
		idle(5);
		`CHK(status_byte[STB_OPER_SUM], 1'b1)
		`CHK(service_request, 1'b1)
		rd(CMD_OPER_EVENT_RD, 8'h02);
		rd(CMD_OPER_COND_RD, 8'h02);
		rd(CMD_OPER_EVENT_RD, 8'h00);
		{power_limit, ramp_done, compliance_limit} <= 3'b101;
		idle(5);
		`CHK(status_byte[STB_OPER_SUM], 1'b0)
		rd(CMD_OPER_EVENT_RD, 8'h05);
		{power_limit, ramp_done, compliance_limit} <= 3'b000;
		pulse(3'b010);
		idle(4);
		wr(CMD_CLEAR_STATUS, 8'h00);
		rd(CMD_OPER_EVENT_RD, 8'h00);
		rd(CMD_STD_EVENT_RD, 8'h00);
		pulse(3'b010);
		rd(CMD_STD_EVENT_RD, 8'h00);
		rd(CMD_STD_EVENT_RD, 8'h10);
		wr(CMD_STD_MASK_WR, 8'h00);
		rd(CMD_STD_MASK_RD, 8'h00);
		rd(CMD_SERIAL_POLL, 8'h40);
		wr(CMD_SVC_MASK_WR, 8'h10);
		{message_available, hw_error_summary, op_error_summary} <= 3'b111;
		idle(5);
		`CHK(status_byte, 8'h56)
		`CHK(service_request, 1'b1)
		end_sim;
	end
endmodule
`default_nettype wire
